/* logic/irc_attempt_win.v */
// Sliding-window restart attempt counter for one fault class.
// Assumes now_i advances once per tick and wraps far beyond WIN.
`timescale 1ns/1ps
`default_nettype none
module irc_attempt_win #(
  parameter DEPTH = 16,
  parameter WIN = 6000
) (
  input wire clk_i,
  input wire reset_i,
  input wire [15:0] now_i,
  input wire record_i,
  input wire [4:0] max_i,
  output reg allow_o,
  output reg [4:0] count_o
);
  localparam integer WIN_I = WIN;
  localparam [15:0] WIN_T = WIN_I[15:0]; // Window in ticks, timestamp width
  reg [15:0] ts_mem [0:DEPTH-1]; // Attempt timestamps
  reg [DEPTH-1:0] vld_reg; // Slot holds a live attempt
  reg [3:0] wr_ptr_reg; // Oldest slot, reused next
  integer i;

  // Number of live attempts
  function [4:0] live_cnt;
    input [DEPTH-1:0] v;
    integer k;
    begin
      live_cnt = 5'h00;
      for (k = 0; k < DEPTH; k = k + 1) begin
        live_cnt = live_cnt + {4'h0, v[k]};
      end
    end
  endfunction

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      vld_reg <= {DEPTH{1'b0}};
      wr_ptr_reg <= 4'h0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        ts_mem[i] <= 16'h0000;
      end
    end else begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        // Modulo age is safe, window is short
        if ((now_i - ts_mem[i]) >= WIN_T) begin
          vld_reg[i] <= 1'b0;
        end
      end
      // Recording wins over expiry of that slot
      if (record_i) begin
        ts_mem[wr_ptr_reg] <= now_i;
        vld_reg[wr_ptr_reg] <= 1'b1;
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
    end
  end

  // Registered count and permission
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_o <= 5'h00;
      allow_o <= 1'b1;
    end else begin
      count_o <= live_cnt(vld_reg);
      allow_o <= live_cnt(vld_reg) < max_i;
    end
  end
endmodule
`default_nettype wire

/* logic/irc_defines.vh */
// Constants for the ramp and restart control block.
// Assumes a 200 MHz clock and settings given in 0.1 units.
`ifndef IRC_DEFINES_VH
`define IRC_DEFINES_VH

// Clock and base tick
`define IRC_CLK_HZ 200000000
`define IRC_TICK_MS 100
`define IRC_TICK_CYCLES (`IRC_CLK_HZ / 1000 * `IRC_TICK_MS)
// Attempt window, minutes, and in 0.1 s ticks
`define IRC_WINDOW_MIN 10
`define IRC_WINDOW_TICKS (`IRC_WINDOW_MIN * 60 * 1000 / `IRC_TICK_MS)

// Mode codes
`define IRC_STAB_ALWAYS 2'h0
`define IRC_STAB_NEVER 2'h1
`define IRC_STAB_NO_DECEL 2'h2
`define IRC_CHG_INPUT 1'h0
`define IRC_CHG_FREQ 1'h1
`define IRC_RST_OFF 2'h0
`define IRC_RST_FSTART 2'h1
`define IRC_RST_SYNC_ACC 2'h2
`define IRC_RST_SYNC_BRK 2'h3

// Fault classes
`define IRC_FC_NONE 2'h0
`define IRC_FC_OC 2'h1
`define IRC_FC_OV 2'h2
`define IRC_FC_UV 2'h3

// Attempt limits
`define IRC_MAX_OC 5'h04
`define IRC_MAX_OV 5'h03
`define IRC_MAX_UV 5'h10

// Second ramp time, 0.1 s units
`define IRC_T2_MIN 16'h0001
`define IRC_T2_FINE_MAX 16'h270F
`define IRC_T2_MAX 16'h7530
`define IRC_T2_RESET 16'h0096
// Changeover frequency limit, 0.1 Hz
`define IRC_FREQ_MAX 12'hE10
// Tolerance and delay, 0.1 s units
`define IRC_TOL_MIN 10'h003
`define IRC_TOL_MAX 10'h0FA
`define IRC_DLY_MIN 10'h003
`define IRC_DLY_MAX 10'h3E8
// Stabiliser reference reset (V)
`define IRC_VREF_LO_RESET 9'h0E6
`define IRC_VREF_HI_RESET 9'h190

`endif

/* logic/irc_ramp_restart_top.v */
// Ramp selection, stabiliser control and fault restart sequencer.
// Assumes settings arrive from parameter software on this clock;
// fault lines, run/start command and ramp-select come from pins.
`timescale 1ns/1ps
`default_nettype none
`include "irc_defines.vh"
module irc_ramp_restart_top #(
  parameter TICK_CYCLES = `IRC_TICK_CYCLES,
  parameter WINDOW_TICKS = `IRC_WINDOW_TICKS
) (
  input wire clk_i,
  input wire reset_i,
  // Stabiliser settings and state
  input wire [1:0] stabiliser_mode_sel_i,
  input wire [8:0] stabiliser_voltage_ref_i,
  input wire series_high_i,
  input wire running_i,
  input wire accelerating_i,
  input wire decelerating_i,
  output reg stabiliser_enable_o,
  output reg [8:0] stabiliser_voltage_ref_o,
  output reg stabiliser_ref_bad_o,
  // Ramp settings
  input wire ramp_select_input_i,
  input wire ramp_changeover_mode_i,
  input wire [11:0] output_freq_i,
  input wire [11:0] accel_changeover_freq_i,
  input wire [11:0] decel_changeover_freq_i,
  input wire [15:0] first_accel_time_i,
  input wire [15:0] first_decel_time_i,
  input wire [15:0] second_accel_time_i,
  input wire [15:0] second_decel_time_i,
  input wire accel_curve_sel_i,
  input wire decel_curve_sel_i,
  output reg [15:0] accel_time_o,
  output reg [15:0] decel_time_o,
  output reg second_ramp_o,
  output reg accel_s_curve_o,
  output reg decel_s_curve_o,
  // Restart settings and faults
  input wire [1:0] restart_mode_sel_i,
  input wire [9:0] power_loss_tolerance_i,
  input wire [9:0] restart_delay_time_i,
  input wire overcurrent_fault_i,
  input wire overvoltage_fault_a_i,
  input wire overvoltage_fault_b_i,
  input wire undervoltage_i,
  input wire other_fault_i,
  input wire start_cmd_i,
  input wire motor_stopped_i,
  input wire fault_reset_i,
  output reg fault_msg_o,
  output reg [1:0] fault_class_o,
  output reg undervoltage_fault_o,
  output reg output_inhibit_o,
  output reg restart_wait_o,
  output reg restart_fstart_o,
  output reg restart_sync_o,
  output reg restart_brake_o
);

  ////////////////////////////////////////////////////////////////
  // Local constants and helpers
  ////////////////////////////////////////////////////////////////

  localparam [2:0] ST_RUN = 3'h0; // Normal operation
  localparam [2:0] ST_WAIT = 3'h1; // Restart delay
  localparam [2:0] ST_PEND = 3'h2; // Waiting for start
  localparam [2:0] ST_BRAKE = 3'h3; // Mode 03 braking
  localparam [2:0] ST_FAULT = 3'h4; // Fault latched

  // Second ramp time legal: fine steps, then whole seconds
  function t2_ok;
    input [15:0] t;
    begin
      if (t < `IRC_T2_MIN || t > `IRC_T2_MAX) begin
        t2_ok = 1'b0;
      end else if (t > `IRC_T2_FINE_MAX) begin
        t2_ok = (t % 16'h000A) == 16'h0000;
      end else begin
        t2_ok = 1'b1;
      end
    end
  endfunction

  // Clamp a 0.1 s setting into its legal range
  function [9:0] clamp10;
    input [9:0] v;
    input [9:0] lo;
    input [9:0] hi;
    begin
      if (v < lo) begin
        clamp10 = lo;
      end else if (v > hi) begin
        clamp10 = hi;
      end else begin
        clamp10 = v;
      end
    end
  endfunction

  // Stabiliser reference in the list of the fitted series
  function vref_ok;
    input [8:0] v;
    input hi;
    begin
      if (hi) begin
        vref_ok = (v == 9'h17C) || (v == 9'h190) ||
                  (v == 9'h19F) || (v == 9'h1B8) || (v == 9'h1CC);
      end else begin
        vref_ok = (v == 9'h0C8) || (v == 9'h0DC) ||
                  (v == 9'h0E6) || (v == 9'h0F0);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  ////////////////////////////////////////////////////////////////

  // Order: ramp sel, oc, ov a, ov b, uv, other, start, stopped
  wire [7:0] pin_raw = {motor_stopped_i, start_cmd_i, other_fault_i,
                        undervoltage_i, overvoltage_fault_b_i,
                        overvoltage_fault_a_i, overcurrent_fault_i,
                        ramp_select_input_i};
  reg [7:0] meta_reg; // First stage, read only by stage two
  reg [7:0] sync_reg; // Safe copy
  reg [7:0] prev_reg; // For rising edges

  // Two-stage capture then edge history
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      meta_reg <= pin_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  wire ramp_sel_s = sync_reg[0];
  wire uv_s = sync_reg[4];
  wire start_s = sync_reg[6];
  wire stopped_s = sync_reg[7];
  wire [7:0] rise = sync_reg & ~prev_reg;
  wire oc_evt = rise[1];
  wire ov_evt = rise[2] | rise[3];
  wire other_evt = rise[5];

  ////////////////////////////////////////////////////////////////
  // Time base
  ////////////////////////////////////////////////////////////////

  wire tick; // 0.1 s enable
  reg [15:0] now_reg; // Timestamp clock in ticks

  irc_tick_div #(
    .CYCLES(TICK_CYCLES),
    .CNT_W(25)
  ) u_div (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  // Running timestamp for attempt windows
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      now_reg <= 16'h0000;
    end else if (tick) begin
      now_reg <= now_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Stabiliser control
  ////////////////////////////////////////////////////////////////

  // Mode decode, unknown code acts as default
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stabiliser_enable_o <= 1'b0;
    end else begin
      case (stabiliser_mode_sel_i)
        `IRC_STAB_ALWAYS: stabiliser_enable_o <= running_i;
        `IRC_STAB_NEVER: stabiliser_enable_o <= 1'b0;
        default: stabiliser_enable_o <= running_i & ~decelerating_i;
      endcase
    end
  end

  // Accept listed references only, else keep last
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stabiliser_voltage_ref_o <= `IRC_VREF_LO_RESET;
      stabiliser_ref_bad_o <= 1'b0;
    end else if (vref_ok(stabiliser_voltage_ref_i, series_high_i)) begin
      stabiliser_voltage_ref_o <= stabiliser_voltage_ref_i;
      stabiliser_ref_bad_o <= 1'b0;
    end else begin
      stabiliser_ref_bad_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Ramp selection
  ////////////////////////////////////////////////////////////////

  reg [15:0] acc2_reg; // Last legal second accel time
  reg [15:0] dec2_reg; // Last legal second decel time
  reg use2_next; // Second ramp wanted

  // Hold only legal second ramp times
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc2_reg <= `IRC_T2_RESET;
      dec2_reg <= `IRC_T2_RESET;
    end else begin
      if (t2_ok(second_accel_time_i)) begin
        acc2_reg <= second_accel_time_i;
      end
      if (t2_ok(second_decel_time_i)) begin
        dec2_reg <= second_decel_time_i;
      end
    end
  end

  // Out-of-range thresholds saturate at the top frequency
  wire [11:0] acc_cf = (accel_changeover_freq_i > `IRC_FREQ_MAX) ?
                       `IRC_FREQ_MAX : accel_changeover_freq_i;
  wire [11:0] dec_cf = (decel_changeover_freq_i > `IRC_FREQ_MAX) ?
                       `IRC_FREQ_MAX : decel_changeover_freq_i;

  // Changeover choice
  always @* begin
    if (ramp_changeover_mode_i == `IRC_CHG_INPUT) begin
      use2_next = ramp_sel_s;
    end else if (decelerating_i) begin
      use2_next = output_freq_i >= dec_cf;
    end else begin
      use2_next = output_freq_i >= acc_cf;
    end
  end

  // Ramp times and curve shapes out
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      second_ramp_o <= 1'b0;
      accel_time_o <= 16'h0000;
      decel_time_o <= 16'h0000;
      accel_s_curve_o <= 1'b0;
      decel_s_curve_o <= 1'b0;
    end else begin
      second_ramp_o <= use2_next;
      accel_time_o <= use2_next ? acc2_reg : first_accel_time_i;
      decel_time_o <= use2_next ? dec2_reg : first_decel_time_i;
      accel_s_curve_o <= accel_curve_sel_i;
      decel_s_curve_o <= decel_curve_sel_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Undervoltage tolerance
  ////////////////////////////////////////////////////////////////

  reg [9:0] uv_cnt_reg; // Undervoltage duration
  wire [9:0] tol = clamp10(power_loss_tolerance_i, `IRC_TOL_MIN,
                           `IRC_TOL_MAX);
  // Fault only once duration passes tolerance
  wire uv_evt = uv_s & tick & (uv_cnt_reg == tol);

  // Duration count, cleared when supply returns
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      uv_cnt_reg <= 10'h000;
    end else if (!uv_s) begin
      uv_cnt_reg <= 10'h000;
    end else if (tick && uv_cnt_reg <= tol) begin
      uv_cnt_reg <= uv_cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Attempt windows
  ////////////////////////////////////////////////////////////////

  reg rec_oc; // Record an overcurrent attempt
  reg rec_ov; // Record an overvoltage attempt
  reg rec_uv; // Record an undervoltage attempt
  wire ok_oc;
  wire ok_ov;
  wire ok_uv;

  irc_attempt_win #(.DEPTH(16), .WIN(WINDOW_TICKS)) u_win_oc (
    .clk_i(clk_i), .reset_i(reset_i), .now_i(now_reg),
    .record_i(rec_oc), .max_i(`IRC_MAX_OC),
    .allow_o(ok_oc), .count_o()
  );
  irc_attempt_win #(.DEPTH(16), .WIN(WINDOW_TICKS)) u_win_ov (
    .clk_i(clk_i), .reset_i(reset_i), .now_i(now_reg),
    .record_i(rec_ov), .max_i(`IRC_MAX_OV),
    .allow_o(ok_ov), .count_o()
  );
  irc_attempt_win #(.DEPTH(16), .WIN(WINDOW_TICKS)) u_win_uv (
    .clk_i(clk_i), .reset_i(reset_i), .now_i(now_reg),
    .record_i(rec_uv), .max_i(`IRC_MAX_UV),
    .allow_o(ok_uv), .count_o()
  );

  ////////////////////////////////////////////////////////////////
  // Restart sequencer
  ////////////////////////////////////////////////////////////////

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] cls_reg; // Fault class under handling
  reg [1:0] cls_next;
  reg [9:0] dly_reg; // Delay elapsed, ticks
  reg [1:0] evt_cls; // Class of this cycle's event
  reg evt_ok; // Window still has room
  wire [9:0] dly = clamp10(restart_delay_time_i, `IRC_DLY_MIN,
                           `IRC_DLY_MAX);

  // Event priority: overcurrent, overvoltage, undervoltage
  always @* begin
    if (oc_evt) begin
      evt_cls = `IRC_FC_OC;
      evt_ok = ok_oc;
    end else if (ov_evt) begin
      evt_cls = `IRC_FC_OV;
      evt_ok = ok_ov;
    end else if (uv_evt) begin
      evt_cls = `IRC_FC_UV;
      evt_ok = ok_uv;
    end else begin
      evt_cls = `IRC_FC_NONE;
      evt_ok = 1'b0;
    end
  end

  // Next state; the restart mode is read at each OC, OV or UV fault and again at the start command in ST_PEND
  always @* begin
    state_next = state_reg;
    cls_next = cls_reg;
    rec_oc = 1'b0;
    rec_ov = 1'b0;
    rec_uv = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (other_evt) begin
          state_next = ST_FAULT;
          cls_next = `IRC_FC_NONE;
        end else if (evt_cls != `IRC_FC_NONE) begin
          cls_next = evt_cls;
          if (restart_mode_sel_i == `IRC_RST_OFF || !evt_ok) begin
            state_next = ST_FAULT;
          end else begin
            state_next = ST_WAIT;
            rec_oc = evt_cls == `IRC_FC_OC;
            rec_ov = evt_cls == `IRC_FC_OV;
            rec_uv = evt_cls == `IRC_FC_UV;
          end
        end
      end
      ST_WAIT: begin
        if (tick && dly_reg + 10'h001 >= dly) begin
          state_next = ST_PEND;
        end
      end
      ST_PEND: begin
        if (start_s) begin
          if (restart_mode_sel_i == `IRC_RST_SYNC_BRK) begin
            state_next = ST_BRAKE;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_BRAKE: begin
        if (stopped_s) begin
          state_next = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (fault_reset_i) begin
          state_next = ST_RUN;
          cls_next = `IRC_FC_NONE;
        end
      end
      default: begin
        state_next = ST_FAULT;
      end
    endcase
  end

  // State, class and delay registers
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_RUN;
      cls_reg <= `IRC_FC_NONE;
      dly_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      cls_reg <= cls_next;
      if (state_reg != ST_WAIT) begin
        dly_reg <= 10'h000;
      end else if (tick) begin
        dly_reg <= dly_reg + 1'b1;
      end
    end
  end

  // Registered sequencer outputs
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_msg_o <= 1'b0;
      fault_class_o <= `IRC_FC_NONE;
      undervoltage_fault_o <= 1'b0;
      output_inhibit_o <= 1'b0;
      restart_wait_o <= 1'b0;
      restart_fstart_o <= 1'b0;
      restart_sync_o <= 1'b0;
      restart_brake_o <= 1'b0;
    end else begin
      fault_msg_o <= state_next == ST_FAULT;
      fault_class_o <= cls_next;
      undervoltage_fault_o <= (state_next == ST_FAULT) &&
                              (cls_next == `IRC_FC_UV);
      output_inhibit_o <= (state_next == ST_WAIT) ||
                          (state_next == ST_PEND) ||
                          (state_next == ST_FAULT);
      restart_wait_o <= state_next == ST_WAIT;
      restart_fstart_o <= (state_reg == ST_PEND) && start_s &&
                          (restart_mode_sel_i == `IRC_RST_FSTART);
      restart_sync_o <= (state_reg == ST_PEND) && start_s &&
                        (restart_mode_sel_i[1] == 1'b1);
      restart_brake_o <= state_next == ST_BRAKE;
    end
  end

endmodule
`default_nettype wire

/* logic/irc_tick_div.v */
// Divider giving a one-cycle 0.1 s tick enable.
// Assumes one clock domain; no gating of the clock.
`timescale 1ns/1ps
`default_nettype none
module irc_tick_div #(
  parameter CYCLES = 20000000,
  parameter CNT_W = 25
) (
  input wire clk_i,
  input wire reset_i,
  output reg tick_o
);
  // Terminal count, cut to counter width on purpose
  localparam integer LAST_I = CYCLES - 1;
  localparam [CNT_W-1:0] LAST = LAST_I[CNT_W-1:0];
  reg [CNT_W-1:0] cnt_reg; // Cycle counter

  // Free-running divider, pulse on wrap
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= {CNT_W{1'b0}};
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verif/irc_chk_assertions.sv */
// Checker of the ramp and restart control top, bound to its ports.
// Assumes one clock domain and the asynchronous high reset.
`timescale 1ns/1ps
`default_nettype none
module irc_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [1:0] stabiliser_mode_sel_i,
  input wire logic decelerating_i,
  input wire logic stabiliser_enable_o,
  input wire logic [8:0] stabiliser_voltage_ref_o,
  input wire logic ramp_changeover_mode_i,
  input wire logic ramp_select_input_i,
  input wire logic second_ramp_o,
  input wire logic [1:0] restart_mode_sel_i,
  input wire logic restart_wait_o,
  input wire logic output_inhibit_o,
  input wire logic restart_fstart_o,
  input wire logic restart_sync_o,
  input wire logic restart_brake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Reference values of both series lists
  wire ref_ok = stabiliser_voltage_ref_o inside {9'h0C8, 9'h0DC, 9'h0E6, 9'h0F0, 9'h17C, 9'h190, 9'h19F,
    9'h1B8, 9'h1CC};
  stab_never_a: assert property (stabiliser_mode_sel_i == 2'h1 |=> !stabiliser_enable_o) else $error("stab on");
  stab_decel_a: assert property (stabiliser_mode_sel_i == 2'h2 && decelerating_i |=> !stabiliser_enable_o)
    else $error("stab on in decel");
  ref_legal_a: assert property (!$stable(stabiliser_voltage_ref_o) |-> ref_ok) else $error("bad ref taken");
  // Four cycles covers the two sync stages and the output register
  ramp_input_a: assert property ((!ramp_changeover_mode_i && ramp_select_input_i) [*4] |=> second_ramp_o)
    else $error("second ramp missing");
  wait_inhibit_a: assert property (restart_wait_o |-> output_inhibit_o) else $error("wait not inhibited");
  start_after_a: assert property (restart_fstart_o || restart_sync_o |-> !$past(restart_wait_o))
    else $error("restart during delay");
  fstart_mode_a: assert property (restart_fstart_o |-> restart_mode_sel_i == 2'h1 ##1 !restart_fstart_o)
    else $error("bad start pulse");
  no_restart_a: assert property (restart_mode_sel_i == 2'h0 && $past(restart_mode_sel_i) == 2'h0
    |-> !restart_fstart_o && !restart_sync_o) else $error("restart in mode 0");
  brake_mode_a: assert property (restart_brake_o |-> restart_mode_sel_i == 2'h3) else $error("brake mode");
  cover property (restart_fstart_o);
  cover property (restart_sync_o);
  cover property (restart_brake_o);
  cover property (second_ramp_o);
endmodule
bind irc_ramp_restart_top irc_chk u_chk (.*);
`default_nettype wire

/* verif/irc_motor_model.sv */
// Motor model: coasts to standstill a few cycles into braking.
// Assumes the brake level comes from the block under test.
`timescale 1ns/1ps
`default_nettype none
module irc_motor_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic brake_i,
  output logic stopped_o
);
  logic [3:0] cnt_reg; // Cycles braked so far
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) cnt_reg <= 4'h0;
    else if (!brake_i) cnt_reg <= 4'h0; // Spinning again once released
    else if (cnt_reg != 4'h8) cnt_reg <= cnt_reg + 4'h1;
  end
  assign stopped_o = (cnt_reg == 4'h8);
endmodule
`default_nettype wire

/* verif/irc_ramp_restart_top_tb.sv */
// Testbench of the ramp and restart control top with a motor model.
// Assumes short tick and window parameters to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module irc_ramp_restart_top_tb;
  logic clk_i, reset_i, series_high_i, running_i, accelerating_i, decelerating_i, ramp_select_input_i;
  logic ramp_changeover_mode_i, accel_curve_sel_i, decel_curve_sel_i, start_cmd_i, fault_reset_i;
  logic [1:0] stabiliser_mode_sel_i, restart_mode_sel_i, fault_class_o;
  logic [8:0] stabiliser_voltage_ref_i, stabiliser_voltage_ref_o;
  logic [11:0] output_freq_i, accel_changeover_freq_i, decel_changeover_freq_i;
  logic [15:0] first_accel_time_i, first_decel_time_i, second_accel_time_i, second_decel_time_i;
  logic [15:0] accel_time_o, decel_time_o;
  logic [9:0] power_loss_tolerance_i, restart_delay_time_i;
  logic [4:0] flt; // Fault pins: OC, OV a, OV b, UV, other
  logic motor_stopped_i, stabiliser_enable_o, stabiliser_ref_bad_o, second_ramp_o, accel_s_curve_o;
  logic decel_s_curve_o, fault_msg_o, undervoltage_fault_o, output_inhibit_o, restart_wait_o;
  logic restart_fstart_o, restart_sync_o, restart_brake_o;
  logic [1:0] cls [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h0}; // Class of each fault pin
  logic [11:0] fq [4] = '{12'h0C7, 12'h0C8, 12'h064, 12'h031}; // Frequency steps
  int lim [3] = '{4, 3, 16}; // Attempts allowed for OC, OV and UV
  int fail_count = 0, compares = 0, i, k;
  // Window of 300 ticks holds all sixteen undervoltage attempts
  irc_ramp_restart_top #(.TICK_CYCLES(10), .WINDOW_TICKS(300)) uut (.*, .overcurrent_fault_i(flt[0]),
    .overvoltage_fault_a_i(flt[1]), .overvoltage_fault_b_i(flt[2]), .undervoltage_i(flt[3]), .other_fault_i(flt[4]));
  irc_motor_model u_motor (.clk_i, .reset_i, .brake_i(restart_brake_o), .stopped_o(motor_stopped_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function logic cond(input int s);
    case (s)
      0: cond = restart_wait_o;
      1: cond = !restart_wait_o;
      2: cond = fault_msg_o;
      3: cond = restart_fstart_o;
      default: cond = restart_sync_o;
    endcase
  endfunction
  // Bounded wait, sampling just after each edge settles
  task wt(input int s);
    int n;
    n = 0;
    #1;
    while (n < 300 && cond(s) !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask
  // Undervoltage is a level, so it is held past the tolerance
  task pulse(input int p);
    cyc(1);
    flt[p] <= 1'b1;
    cyc(p == 3 ? 60 : 3);
    flt[p] <= 1'b0;
  endtask
  task clr;
    cyc(1);
    fault_reset_i <= 1'b1;
    cyc(1);
    fault_reset_i <= 1'b0;
    cyc(2);
  endtask
  task test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    test_done;
  end
  initial begin
    {series_high_i, decelerating_i, ramp_select_input_i, ramp_changeover_mode_i, accelerating_i} = '0;
    {accel_curve_sel_i, decel_curve_sel_i, start_cmd_i, fault_reset_i, flt} = '0;
    {stabiliser_mode_sel_i, restart_mode_sel_i, output_freq_i, decel_changeover_freq_i} = '0;
    reset_i = 1'b1;
    running_i = 1'b1;
    stabiliser_voltage_ref_i = 9'h0E6;
    accel_changeover_freq_i = 12'h0C8;
    first_accel_time_i = 16'h0032;
    first_decel_time_i = 16'h0028;
    second_accel_time_i = 16'h0014;
    second_decel_time_i = 16'h0096;
    power_loss_tolerance_i = 10'h003;
    restart_delay_time_i = 10'h003;
    cyc(3);
    reset_i <= 1'b0;
    #1 chk(stabiliser_voltage_ref_o, 9'h0E6);
    for (i = 0; i < 6; i++) begin
      cyc(1);
      stabiliser_mode_sel_i <= 2'(i / 2);
      decelerating_i <= i[0];
      cyc(2);
      #1 chk(stabiliser_enable_o, i < 2 || i == 4);
    end
    // Lower series list, then higher series with supply as reference
    cyc(1);
    stabiliser_voltage_ref_i <= 9'h0DC;
    cyc(2);
    #1 chk(stabiliser_voltage_ref_o, 9'h0DC);
    cyc(1);
    stabiliser_voltage_ref_i <= 9'h190;
    cyc(2);
    #1 chk({stabiliser_ref_bad_o, stabiliser_voltage_ref_o}, 10'h2DC);
    cyc(1);
    series_high_i <= 1'b1;
    stabiliser_voltage_ref_i <= 9'h1B8;
    cyc(2);
    #1 chk({stabiliser_ref_bad_o, stabiliser_voltage_ref_o}, 10'h1B8);
    cyc(1);
    ramp_select_input_i <= 1'b1;
    cyc(5);
    #1 chk({second_ramp_o, accel_time_o}, 17'h10014);
    chk(decel_time_o, 16'h0096);
    cyc(1);
    second_accel_time_i <= 16'h2715; // Not on the coarse step
    cyc(3);
    #1 chk(accel_time_o, 16'h0014);
    cyc(1);
    second_accel_time_i <= 16'h271A;
    cyc(3);
    #1 chk(accel_time_o, 16'h271A);
    cyc(1);
    ramp_select_input_i <= 1'b0;
    cyc(5);
    #1 chk(accel_time_o, 16'h0032);
    chk(decel_time_o, 16'h0028);
    cyc(1);
    ramp_changeover_mode_i <= 1'b1;
    decel_changeover_freq_i <= 12'h032;
    for (i = 0; i < 4; i++) begin
      cyc(1);
      output_freq_i <= fq[i];
      decelerating_i <= i > 1;
      cyc(2);
      #1 chk(second_ramp_o, i == 1 || i == 2);
    end
    for (i = 0; i < 2; i++) begin
      cyc(1);
      accel_curve_sel_i <= i[0];
      decel_curve_sel_i <= !i[0];
      cyc(2);
      #1 chk(accel_s_curve_o, i[0]);
      chk(decel_s_curve_o, !i[0]);
    end
    // Brief undervoltage inside the tolerance is not a fault
    cyc(1);
    decelerating_i <= 1'b0;
    flt[3] <= 1'b1;
    cyc(20);
    flt[3] <= 1'b0;
    cyc(10);
    #1 chk(fault_msg_o, 0);
    for (i = 0; i < 5; i++) begin
      pulse(i);
      wt(2);
      chk(fault_msg_o, 1);
      chk(fault_class_o, cls[i]);
      chk(undervoltage_fault_o, i == 3);
      clr;
    end
    // Delay outlasts the undervoltage hold, so waiting is still seen
    restart_mode_sel_i <= 2'h1;
    restart_delay_time_i <= 10'h00A;
    for (i = 0; i < 3; i++) begin
      for (k = 0; k <= lim[i]; k++) begin
        pulse(i < 2 ? i : 3);
        wt(k < lim[i] ? 0 : 2);
        if (k < lim[i]) begin
          chk({restart_wait_o, output_inhibit_o}, 2'h3);
          wt(1);
          chk(output_inhibit_o, 1);
          cyc(1);
          start_cmd_i <= 1'b1;
          wt(3);
          chk(restart_fstart_o, 1);
          cyc(1);
          start_cmd_i <= 1'b0;
          #1 chk({restart_fstart_o, output_inhibit_o}, 2'h0);
        end else chk(fault_msg_o, 1);
      end
      clr;
    end
    // Old attempts age out, then synchronising restarts
    restart_mode_sel_i <= 2'h2;
    restart_delay_time_i <= 10'h005;
    cyc(800);
    for (i = 2; i < 4; i++) begin
      pulse(0);
      wt(0);
      chk(restart_wait_o, 1);
      wt(1);
      cyc(1);
      start_cmd_i <= 1'b1;
      wt(4);
      chk({restart_sync_o, restart_brake_o}, {1'b1, i == 3});
      cyc(1);
      start_cmd_i <= 1'b0;
      restart_mode_sel_i <= 2'h3;
    end
    #1 chk(restart_brake_o, 1);
    wt(2);
    chk(fault_msg_o, 1);
    clr;
    test_done;
  end
endmodule
`default_nettype wire
